/* File: rtl/watchdog_timer_two.sv */
// Watchdog timer with one-shot mode register, restart key and APB access.
`timescale 1ns/1ps
module watchdog_timer_two (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic        bit_op,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Count sources.
    input  wire logic        int_osc_clk_in,
    input  wire logic        main_clk_in,
    input  wire logic        sub_clk_in,
    input  wire logic        int_osc_stop,
    input  wire logic        osc_stab,
    // Overflow actions.
    output logic             wd_internal_reset,
    output logic             wd_nmi_request,
    output logic             cpu_clk_to_int_osc
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [7:0]        mode;
        wd_pkg::wr_state_e wr;
        logic [31:0]       rdata;
        logic              err;
        logic              rst_o;
        logic              nmi_o;
        logic              sw_o;
    } main_s;

    main_s                    st_q;
    main_s                    st_d;
    logic                     int_rise;
    logic                     main_rise;
    logic                     sub_rise;
    logic                     tick;
    logic                     wrap;
    logic                     cnt_clear;
    logic [wd_pkg::CNT_W-1:0] count;
    logic                     setup;
    logic                     wr_acc;
    logic                     hit_mode;
    logic                     hit_restart;
    logic                     hit_status;
    logic                     running;
    logic                     force_ovf;
    logic                     restart_ok;
    logic                     first_wr;
    logic                     ovf;

    ////////////////////////////////////////////////////////////////////////
    // Source synchronisers and counter.

    wd_edge_sync u_int_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .src_in  (int_osc_clk_in),
        .rise    (int_rise)
    );

    wd_edge_sync u_main_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .src_in  (main_clk_in),
        .rise    (main_rise)
    );

    wd_edge_sync u_sub_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .src_in  (sub_clk_in),
        .rise    (sub_rise)
    );

    // pick the tick of the selected source.
    always_comb begin
        unique case (wd_pkg::source_of(st_q.mode[4:0]))
            // internal ticks stop with the oscillator.
            wd_pkg::SRC_INT:  tick = int_rise & ~int_osc_stop;
            wd_pkg::SRC_MAIN: tick = main_rise;
            wd_pkg::SRC_SUB:  tick = sub_rise;
            default:          tick = 1'b0;
        endcase
    end

    // tap position follows the clock-selection code.
    // subclock codes ignore the second selection bit.
    wd_interval_counter u_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick & running),
        .clear   (cnt_clear),
        .width   (wd_pkg::interval_bits(st_q.mode[4:0])),
        .wrap    (wrap),
        .count   (count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and overflow sources.

    // Address decode and phase qualifiers.
    assign setup       = psel & ~penable;
    assign wr_acc      = psel & penable & pwrite;
    assign hit_mode    = (paddr == wd_pkg::MODE_ADDR);
    assign hit_restart = (paddr == wd_pkg::RESTART_ADDR);
    assign hit_status  = (paddr == wd_pkg::STATUS_ADDR);

    assign running = st_q.mode[wd_pkg::MODE_HI_BIT] | st_q.mode[wd_pkg::MODE_LO_BIT];

    // only the first mode write after reset is taken.
    assign first_wr = wr_acc & hit_mode & (st_q.wr == wd_pkg::WR_OPEN);

    // the key value restarts the count.
    assign restart_ok = wr_acc & hit_restart & ~bit_op
                        & (pwdata[7:0] == wd_pkg::RESTART_KEY);

    // a repeated mode write forces an overflow.
    // a wrong restart value forces an overflow.
    // a bit operation on the restart register forces one too.
    // none of these act while stopped.
    assign force_ovf = running & wr_acc & (
                           (hit_mode & (st_q.wr == wd_pkg::WR_LOCKED))
                         | (hit_restart & (bit_op | (pwdata[7:0] != wd_pkg::RESTART_KEY))));

    assign ovf       = force_ovf | (running & wrap);
    assign cnt_clear = ovf | restart_ok | first_wr;

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    // Register writes, read data and overflow actions.
    always_comb begin
        st_d       = st_q;
        st_d.rst_o = 1'b0;
        st_d.nmi_o = 1'b0;
        st_d.sw_o  = 1'b0;
        if (setup) begin
            st_d.err   = ~(hit_mode | hit_restart | hit_status);
            st_d.rdata = '0;
            if (hit_mode) begin
                st_d.rdata[7:0] = st_q.mode & wd_pkg::MODE_WMASK;
            end else if (hit_restart) begin
                st_d.rdata[7:0] = wd_pkg::RESTART_READ;
            end else if (hit_status) begin
                st_d.rdata[wd_pkg::STAT_WRITTEN_BIT] = (st_q.wr == wd_pkg::WR_LOCKED);
                st_d.rdata[wd_pkg::STAT_RUNNING_BIT] = running;
            end
        end
        if (first_wr) begin
            st_d.mode = pwdata[7:0] & wd_pkg::MODE_WMASK;
            st_d.wr   = wd_pkg::WR_LOCKED;
        end
        if (ovf) begin
            if (st_q.mode[wd_pkg::MODE_HI_BIT]) begin
                // during stabilisation switch the clock instead.
                st_d.rst_o = ~osc_stab;
                st_d.sw_o  = osc_stab;
            end else begin
                st_d.nmi_o = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // default reset mode starts counting at once.
            // mode register starts at its reset value.
            st_q      <= '0;
            st_q.mode <= wd_pkg::MODE_RESET;
            st_q.wr   <= wd_pkg::WR_OPEN;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs.
    assign prdata             = st_q.rdata;
    assign pslverr            = st_q.err & psel & penable;
    assign pready             = 1'b1;
    assign wd_internal_reset  = st_q.rst_o;
    assign wd_nmi_request     = st_q.nmi_o;
    assign cpu_clk_to_int_osc = st_q.sw_o;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_mode_locked: assert property (
        (st_q.wr == wd_pkg::WR_LOCKED) |=> $stable(st_q.mode))
        else $error("Mode register changed after lock.");

    a_bit7_zero: assert property (
        (setup && hit_mode) |=> (prdata[31:7] == 25'h0))
        else $error("Mode readback has upper bits set.");

    a_restart_read: assert property (
        (setup && hit_restart) |=> (prdata == 32'h0000009a))
        else $error("Restart register read is not 9AH.");

    a_second_write: assert property (
        (running && wr_acc && hit_mode && st_q.wr == wd_pkg::WR_LOCKED)
        |=> ((wd_internal_reset || wd_nmi_request || cpu_clk_to_int_osc)
             && count == '0))
        else $error("Second mode write did not force overflow.");

    a_bad_key: assert property (
        (running && wr_acc && hit_restart && pwdata[7:0] != 8'hac)
        |=> (wd_internal_reset || wd_nmi_request || cpu_clk_to_int_osc))
        else $error("Wrong restart value did not force overflow.");

    a_stop_quiet: assert property (
        (!running && $past(!running))
        |-> !(wd_internal_reset || wd_nmi_request || cpu_clk_to_int_osc))
        else $error("Overflow seen while stopped.");

    a_reset_mode: assert property (
        wd_internal_reset |-> ($past(st_q.mode[6]) && !$past(osc_stab)))
        else $error("Reset pulse outside reset mode or in stabilisation.");

    a_nmi_mode: assert property (
        wd_nmi_request |-> ($past(st_q.mode[6:5]) == 2'b01))
        else $error("NMI pulse outside interrupt mode.");

    a_osc_stop: assert property (
        (wd_pkg::source_of(st_q.mode[4:0]) == wd_pkg::SRC_INT && int_osc_stop
         && !cnt_clear) |=> $stable(count))
        else $error("Count advanced with internal oscillator stopped.");

    a_key_restart: assert property (
        restart_ok |=> (count == '0) ##1 (count <= 25'h1))
        else $error("Key write did not restart the count.");

    a_default_mode: assert property (
        (st_q.wr == wd_pkg::WR_OPEN) |-> (st_q.mode == wd_pkg::MODE_RESET))
        else $error("Mode left its default before the first write.");

    a_first_store: assert property (
        first_wr |=> (st_q.mode == ($past(pwdata[7:0]) & wd_pkg::MODE_WMASK)))
        else $error("First mode write was not stored.");

    a_one_action: assert property (
        $onehot0({wd_internal_reset, wd_nmi_request, cpu_clk_to_int_osc}))
        else $error("More than one overflow action at once.");

    a_pulse_width: assert property (
        (wd_internal_reset || wd_nmi_request || cpu_clk_to_int_osc)
        |=> !(wd_internal_reset || wd_nmi_request || cpu_clk_to_int_osc))
        else $error("Overflow action lasted more than one cycle.");

    a_wrap_action: assert property (
        (running && wrap) |=> (wd_internal_reset || wd_nmi_request || cpu_clk_to_int_osc))
        else $error("Counter wrap gave no overflow action.");

    a_stab_switch: assert property (
        cpu_clk_to_int_osc |-> ($past(st_q.mode[6]) && $past(osc_stab)))
        else $error("Clock switch outside reset-mode stabilisation.");

    a_restart_quiet: assert property (
        (restart_ok && !wrap) |=> !(wd_internal_reset || wd_nmi_request || cpu_clk_to_int_osc))
        else $error("Key write raised an overflow action.");

endmodule : watchdog_timer_two

/* File: rtl/wd_pkg.sv */
// Constants, field layout and helper functions for the watchdog block.
package wd_pkg;

    // Register byte addresses on the APB bus.
    localparam logic [31:0] MODE_ADDR    = 32'hfffff6d0;
    localparam logic [31:0] RESTART_ADDR = 32'hfffff6d4;
    localparam logic [31:0] STATUS_ADDR  = 32'hfffff6d8;

    // Reset values, key values and write masks.
    localparam logic [7:0] MODE_RESET   = 8'h67;
    localparam logic [7:0] MODE_WMASK   = 8'h7f;
    localparam logic [7:0] RESTART_KEY  = 8'hac;
    localparam logic [7:0] RESTART_READ = 8'h9a;

    // Field positions inside the mode register.
    localparam int MODE_HI_BIT = 6;
    localparam int MODE_LO_BIT = 5;
    localparam int CLKSEL_MSB  = 4;
    localparam int CLKSEL_MID  = 3;

    // Status register bit positions.
    localparam int STAT_WRITTEN_BIT = 0;
    localparam int STAT_RUNNING_BIT = 1;

    // Counter width and the tap base of each source.
    localparam int          CNT_W     = 25;
    localparam logic [4:0]  BASE_INT  = 5'h0c;
    localparam logic [4:0]  BASE_MAIN = 5'h12;
    localparam logic [4:0]  BASE_SUB  = 5'h09;

    // Count source chosen by the clock-selection field.
    typedef enum logic [1:0] {
        SRC_INT  = 2'b00,
        SRC_MAIN = 2'b01,
        SRC_SUB  = 2'b11
    } src_e;

    // Lock state of the mode register.
    typedef enum logic {
        WR_OPEN   = 1'b0,
        WR_LOCKED = 1'b1
    } wr_state_e;

    // Source selected by a clock-selection code.
    function automatic src_e source_of(input logic [4:0] sel);
        if (sel[CLKSEL_MSB]) begin
            return SRC_SUB;
        end
        return sel[CLKSEL_MID] ? SRC_MAIN : SRC_INT;
    endfunction : source_of

    // Number of counter bits that make up the selected interval.
    function automatic logic [4:0] interval_bits(input logic [4:0] sel);
        unique case (source_of(sel))
            SRC_INT:  return BASE_INT + {2'h0, sel[2:0]};
            SRC_MAIN: return BASE_MAIN + {2'h0, sel[2:0]};
            SRC_SUB:  return BASE_SUB + {2'h0, sel[2:0]};
            default:  return BASE_INT + {2'h0, sel[2:0]};
        endcase
    endfunction : interval_bits

endpackage : wd_pkg

/* File: rtl/wd_edge_sync.sv */
// Three-stage synchroniser that turns a rising source edge into a tick.
`timescale 1ns/1ps
module wd_edge_sync (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Asynchronous source and its tick.
    input  wire logic src_in,
    output logic      rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    // The level moves only once stages two and three agree.
    always_comb begin
        st_d      = st_q;
        st_d.s1   = src_in;
        st_d.s2   = st_q.s1;
        st_d.s3   = st_q.s2;
        st_d.rise = 1'b0;
        if (st_q.s2 == st_q.s3) begin
            st_d.level = st_q.s3;
            st_d.rise  = st_q.s3 & ~st_q.level;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise = st_q.rise;

endmodule : wd_edge_sync

/* File: rtl/wd_interval_counter.sv */
// Free-running binary counter with a selectable wrap tap.
`timescale 1ns/1ps
module wd_interval_counter (
    // Clock and reset.
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // Control.
    input  wire logic                   tick,
    input  wire logic                   clear,
    input  wire logic [4:0]             width,
    // Result.
    output logic                        wrap,
    output logic [wd_pkg::CNT_W-1:0]    count
);

    typedef struct packed {
        logic [wd_pkg::CNT_W-1:0] cnt;
    } cnt_s;

    cnt_s                     st_q;
    cnt_s                     st_d;
    logic [wd_pkg::CNT_W:0]   mask_w;
    logic [wd_pkg::CNT_W-1:0] mask;

    // Tap mask: the low width bits all set means the interval is done.
    assign mask_w = ({{wd_pkg::CNT_W{1'b0}}, 1'b1} << width) - 1'b1;
    assign mask   = mask_w[wd_pkg::CNT_W-1:0];
    assign wrap   = tick & ((st_q.cnt & mask) == mask);

    // counter clears on restart, wrap and force.
    always_comb begin
        st_d = st_q;
        if (clear || wrap) begin
            st_d.cnt = '0;
        end else if (tick) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count = st_q.cnt;

endmodule : wd_interval_counter

/* File: dv/wd_cpu_side.sv */
// Behavioural model of the CPU reset logic and NMI controller beside the watchdog.
`timescale 1ns/1ps
module wd_cpu_side (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Overflow actions from the watchdog.
    input wire logic wd_internal_reset,
    input wire logic wd_nmi_request,
    input wire logic cpu_clk_to_int_osc
);
    int rst_seen = 0;
    int nmi_seen = 0;
    int sw_seen  = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Each one-cycle pulse is taken as one event; the counts survive the block reset.
    // take overflow actions
    always @(posedge pclk) begin
        if (wd_internal_reset === 1'h1) rst_seen++;
        if (wd_nmi_request === 1'h1) nmi_seen++;
        if (cpu_clk_to_int_osc === 1'h1) sw_seen++;
    end
endmodule : wd_cpu_side

/* File: dv/tb_top.sv */
// Self-checking testbench for the watchdog block.
`timescale 1ns/1ps
module tb_top;
    // Bus, source and status stimulus.
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        bit_op = 1'h0, int_osc_stop = 1'h0, osc_stab = 1'h0;
    logic        int_osc_clk_in = 1'h0, main_clk_in = 1'h0, sub_clk_in = 1'h0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdata;
    logic        pready, pslverr, rerr, wd_internal_reset, wd_nmi_request, cpu_clk_to_int_osc;
    int          bad_count = 0, checks_done = 0, b_rst = 0, b_nmi = 0, b_sw = 0;
    localparam logic [31:0] MODE = 32'hfffff6d0, RESTART = 32'hfffff6d4, NOWHERE = 32'hfffff6dc;
    localparam logic [31:0] STATUS = 32'hfffff6d8;

    watchdog_timer_two DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .bit_op(bit_op),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_osc_clk_in(int_osc_clk_in),
        .main_clk_in(main_clk_in), .sub_clk_in(sub_clk_in), .int_osc_stop(int_osc_stop),
        .osc_stab(osc_stab), .wd_internal_reset(wd_internal_reset),
        .wd_nmi_request(wd_nmi_request), .cpu_clk_to_int_osc(cpu_clk_to_int_osc));
    wd_cpu_side cpu (.pclk(pclk), .presetn(presetn), .wd_internal_reset(wd_internal_reset),
        .wd_nmi_request(wd_nmi_request), .cpu_clk_to_int_osc(cpu_clk_to_int_osc));

    ////////////////////////////////////////////////////////////////////////////////
    // The bus clock runs at 10 MHz.
    initial begin
        forever #50 pclk = ~pclk;
    end

    // Sources toggle every fourth edge so each level outlasts the synchroniser.
    initial begin
        forever begin
            repeat (4) @(posedge pclk);
            sub_clk_in  <= ~sub_clk_in;
            main_clk_in <= ~main_clk_in;
            if (!int_osc_stop) int_osc_clk_in <= ~int_osc_clk_in;
        end
    end

    // A hung run is cut short here.
    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        $display("CHECK FAILED at %0t: run limit reached", $time);
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // Compares a bus value.
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk_reg

    // Compares an event count.
    task automatic chk_cnt(input int got, input int exp, input string msg);
        checks_done++;
        if (got != exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %0d want %0d", $time, msg, got, exp);
        end
    endtask : chk_cnt

    // Lets a pulse land, compares the new events of each kind and rebases.
    task automatic pulses(input int dr, input int dn, input int ds);
        repeat (2) @(posedge pclk);
        chk_cnt(cpu.rst_seen - b_rst, dr, "reset pulses");
        chk_cnt(cpu.nmi_seen - b_nmi, dn, "nmi pulses");
        chk_cnt(cpu.sw_seen - b_sw, ds, "clock switch pulses");
        b_rst = cpu.rst_seen;
        b_nmi = cpu.nmi_seen;
        b_sw  = cpu.sw_seen;
    endtask : pulses

    // One APB transfer; the request holds until pready is seen high at an edge.
    // accesses on bus clock
    task automatic apb(input logic [31:0] a, input logic wr, input logic [31:0] d,
                       input logic bop);
        int n;
        psel    <= 1'h1;
        penable <= 1'h0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        bit_op  <= bop;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rdata = prdata;
        rerr  = pslverr;
        if (pready !== 1'h1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
            report_and_stop();
        end
        psel    <= 1'h0;
        penable <= 1'h0;
        bit_op  <= 1'h0;
        @(posedge pclk);
    endtask : apb

    // Reset held for eight cycles, then event counts rebased.
    task automatic do_reset();
        presetn <= 1'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        pulses(0, 0, 0);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, fixed read value and an unmapped place.
    task automatic t_regs();
        do_reset();
        apb(MODE, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h00000067, "mode after reset");
        apb(RESTART, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h0000009a, "restart after reset");
        apb(NOWHERE, 1'h1, 32'h00000055, 1'h0);
        apb(NOWHERE, 1'h0, 32'h0, 1'h0);
        chk_reg({31'h0, rerr}, 32'h00000001, "unmapped error");
        chk_reg(rdata, 32'h00000000, "unmapped data");
        pulses(0, 0, 0);
        $display("t_regs done");
    endtask : t_regs

    // Restart key, wrong value, bit operation and overflow during stabilisation.
    task automatic t_restart();
        do_reset();
        apb(RESTART, 1'h1, 32'h000000ac, 1'h0);
        pulses(0, 0, 0);
        apb(RESTART, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h0000009a, "restart read back");
        apb(RESTART, 1'h1, 32'h00000055, 1'h0);
        pulses(1, 0, 0);
        apb(RESTART, 1'h1, 32'h000000ac, 1'h1);
        pulses(1, 0, 0);
        osc_stab <= 1'h1;
        apb(RESTART, 1'h1, 32'h00000000, 1'h0);
        pulses(0, 0, 1);
        osc_stab <= 1'h0;
        $display("t_restart done");
    endtask : t_restart

    // One write only; bit 7 fixed; second write forces a reset overflow.
    task automatic t_once();
        do_reset();
        apb(MODE, 1'h1, 32'h000000d0, 1'h0);
        pulses(0, 0, 0);
        apb(MODE, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h00000050, "mode first write");
        apb(MODE, 1'h1, 32'h00000000, 1'h0);
        pulses(1, 0, 0);
        apb(MODE, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h00000050, "mode kept");
        $display("t_once done");
    endtask : t_once

    // Interrupt mode on the subclock: 2^9 ticks of eight cycles after a restart.
    task automatic t_interval();
        int n;
        do_reset();
        apb(MODE, 1'h1, 32'h00000030, 1'h0);
        repeat (3000) @(posedge pclk);
        pulses(0, 0, 0);
        apb(RESTART, 1'h1, 32'h000000ac, 1'h0);
        n = 0;
        while (cpu.nmi_seen == b_nmi && n < 6000) begin
            @(posedge pclk);
            n++;
        end
        chk_cnt(int'(n >= 4080 && n <= 4110), 1, "subclock interval");
        pulses(0, 1, 0);
        apb(MODE, 1'h1, 32'h00000067, 1'h0);
        pulses(0, 1, 0);
        apb(MODE, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h00000030, "interrupt mode kept");
        $display("t_interval done");
    endtask : t_interval

    // Stopped operation never forces an overflow.
    task automatic t_stop();
        do_reset();
        int_osc_stop <= 1'h1;
        apb(MODE, 1'h1, 32'h00000000, 1'h0);
        apb(RESTART, 1'h1, 32'h00000055, 1'h0);
        apb(MODE, 1'h1, 32'h00000067, 1'h0);
        apb(RESTART, 1'h1, 32'h000000ac, 1'h1);
        pulses(0, 0, 0);
        apb(MODE, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h00000000, "stopped mode kept");
        int_osc_stop <= 1'h0;
        $display("t_stop done");
    endtask : t_stop

    // Main-clock source chosen and read back; status shows lock and run state.
    task automatic t_main();
        do_reset();
        apb(STATUS, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h00000002, "status after reset");
        apb(MODE, 1'h1, 32'h00000048, 1'h0);
        apb(MODE, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h00000048, "main source mode");
        apb(STATUS, 1'h0, 32'h0, 1'h0);
        chk_reg(rdata, 32'h00000003, "status after write");
        pulses(0, 0, 0);
        $display("t_main done");
    endtask : t_main

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        t_regs();
        t_restart();
        t_once();
        t_interval();
        t_stop();
        t_main();
        report_and_stop();
    end
endmodule : tb_top
